// *** core/pib_irq_bank.sv ***
// How it works
// [R1] bit 7 of the enable register lets the oscillator-failure request through when set.
// [R2] bit 6 lets the second comparator's request through when set.
// [R3] bit 5 lets the first comparator's request through when set.
// [R4] bit 3 lets the serial port bus-collision request through when set.
// [R5] bit 2 lets the usb request through when set.
// [R6] bits 4 and 0 store nothing, read as zero and ignore writes.
// [R7] every implemented enable bit is read/write and clears to zero on any reset.
// [R8] bit 1 lets the clock tuning request through when set.
// [R9] no request leaves on PERIPH_REQ_O or CORE_IRQ_O unless the peripheral master enable is set; IRQ_O does not depend on it.
// [R10] a pending flag sets on its source event whatever the enables hold.
// [R11] each request is pending and enable, and the requests are or-ed into one.
`timescale 1ns/100ps
`default_nettype none
module pib_irq_bank (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    input wire logic [pib_pkg::ADDR_W-1:0] BUS_ADDR_I,
    input wire logic [pib_pkg::DATA_W-1:0] BUS_WDATA_I,
    output logic [pib_pkg::DATA_W-1:0] BUS_RDATA_O,
    input wire logic [pib_pkg::DATA_W-1:0] SRC_EVENT_I,
    output logic PERIPH_REQ_O,
    output logic CORE_IRQ_O,
    output logic IRQ_O
);
    import pib_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    pib_bus_t bus;
    logic [DATA_W-1:0] enable_q;
    logic [DATA_W-1:0] pending_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] stat_q;
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] src_req;
    logic [DATA_W-1:0] src_req_q;
    logic [DATA_W-1:0] src_rise;
    logic periph_en;
    logic global_en;

    assign bus = '{wr: BUS_WR_I, rd: BUS_RD_I, addr: BUS_ADDR_I, wdata: BUS_WDATA_I};

    function automatic logic hit(input pib_bus_t b, input logic [ADDR_W-1:0] off);
        hit = (b.addr == off);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // enable register: holes at 4 and 0 are masked away inside
    pib_rw_reg #(
        .W(DATA_W),
        .IMPL(SRC_IMPL_MASK),
        .RST(ENABLE_RST)
    ) u_enable (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I), // [R7]
        .we_i(bus.wr && hit(bus, OFF_ENABLE)), // [R7]
        .wdata_i(bus.wdata), // [R6]
        .q_o(enable_q)
    );

    pib_rw_reg #(
        .W(DATA_W),
        .IMPL(CTRL_IMPL_MASK),
        .RST(CTRL_RST)
    ) u_ctrl (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .we_i(bus.wr && hit(bus, OFF_CTRL)),
        .wdata_i(bus.wdata),
        .q_o(ctrl_q)
    );

    pib_rw_reg #(
        .W(DATA_W),
        .IMPL(SRC_IMPL_MASK),
        .RST(MASK_RST)
    ) u_mask (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .we_i(bus.wr && hit(bus, OFF_IRQ_MASK)),
        .wdata_i(bus.wdata),
        .q_o(mask_q)
    );

    // pending flags: software may write them; a source event always wins
    pib_sticky_reg #(
        .W(DATA_W),
        .IMPL(SRC_IMPL_MASK),
        .RST(PENDING_RST)
    ) u_pending (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .set_i(SRC_EVENT_I), // [R10]
        .we_i(bus.wr && hit(bus, OFF_PENDING)),
        .wdata_i(bus.wdata),
        .rd_clr_i(1'b0),
        .q_o(pending_q)
    );

    // ------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------
    assign periph_en = ctrl_q[CTRL_PERIPH_BIT];
    assign global_en = ctrl_q[CTRL_GLOBAL_BIT];

    always_comb begin
        src_req = '0;
        src_req[BIT_OSC_FAIL] = pending_q[BIT_OSC_FAIL] & enable_q[BIT_OSC_FAIL]; // [R1]
        src_req[BIT_CMP_TWO] = pending_q[BIT_CMP_TWO] & enable_q[BIT_CMP_TWO]; // [R2]
        src_req[BIT_CMP_ONE] = pending_q[BIT_CMP_ONE] & enable_q[BIT_CMP_ONE]; // [R3]
        src_req[BIT_SER_COLL] = pending_q[BIT_SER_COLL] & enable_q[BIT_SER_COLL]; // [R4]
        src_req[BIT_USB] = pending_q[BIT_USB] & enable_q[BIT_USB]; // [R5]
        src_req[BIT_CLK_TUNE] = pending_q[BIT_CLK_TUNE] & enable_q[BIT_CLK_TUNE]; // [R8]
    end

    assign PERIPH_REQ_O = periph_en & (|src_req); // [R9] [R11]
    assign CORE_IRQ_O = global_en & PERIPH_REQ_O;

    // ------------------------------------------------------------
    // event status: a newly active request is latched for software
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            src_req_q <= '0;
        end else begin
            src_req_q <= src_req;
        end
    end

    assign src_rise = src_req & ~src_req_q;

    // reading the status clears it, but an edge in that cycle survives
    pib_sticky_reg #(
        .W(DATA_W),
        .IMPL(SRC_IMPL_MASK),
        .RST(PENDING_RST)
    ) u_stat (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .set_i(src_rise),
        .we_i(1'b0),
        .wdata_i(READ_IDLE),
        .rd_clr_i(bus.rd && hit(bus, OFF_IRQ_STAT)),
        .q_o(stat_q)
    );

    assign IRQ_O = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // data stand for one cycle only, zero otherwise, so a stale value
    // cannot be mistaken for a fresh answer
    always_comb begin
        rdata_d = READ_IDLE;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_ENABLE: rdata_d = enable_q & SRC_IMPL_MASK; // [R6]
                OFF_PENDING: rdata_d = pending_q;
                OFF_CTRL: rdata_d = ctrl_q;
                OFF_IRQ_STAT: rdata_d = stat_q;
                OFF_IRQ_MASK: rdata_d = mask_q;
                default: rdata_d = READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            rdata_q <= READ_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign BUS_RDATA_O = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_en_wr(int unsigned b, logic v);
        BUS_WR_I && BUS_ADDR_I == OFF_ENABLE && BUS_WDATA_I[b] == v;
    endsequence

    sequence s_no_en_wr;
        !(BUS_WR_I && BUS_ADDR_I == OFF_ENABLE);
    endsequence

    osc_fail_gate_a: assert property ( // [R1]
        s_en_wr(BIT_OSC_FAIL, 1'b0) ##1 s_no_en_wr [*2] |-> !src_req[BIT_OSC_FAIL]
    ) else $error("osc fail request passed a cleared enable");

    cmp_two_gate_a: assert property ( // [R2]
        s_en_wr(BIT_CMP_TWO, 1'b1) ##1 (s_no_en_wr and pending_q[BIT_CMP_TWO])
        |-> src_req[BIT_CMP_TWO]
    ) else $error("comparator two request blocked by a set enable");

    cmp_one_gate_a: assert property ( // [R3]
        s_en_wr(BIT_CMP_ONE, 1'b0) |=> !src_req[BIT_CMP_ONE]
    ) else $error("comparator one request passed a cleared enable");

    ser_coll_gate_a: assert property ( // [R4]
        s_en_wr(BIT_SER_COLL, 1'b1) ##1 SRC_EVENT_I[BIT_SER_COLL]
        |=> src_req[BIT_SER_COLL] || $past(BUS_WR_I)
    ) else $error("collision request not forwarded");

    usb_gate_a: assert property ( // [R5]
        s_en_wr(BIT_USB, 1'b0) |=> !src_req[BIT_USB]
    ) else $error("usb request passed a cleared enable");

    enable_holes_a: assert property ( // [R6]
        enable_q[BIT_HOLE_HI] == 1'b0 && enable_q[BIT_HOLE_LO] == 1'b0
        && (!$past(BUS_RD_I) || $past(BUS_ADDR_I) != OFF_ENABLE
            || (BUS_RDATA_O & ~SRC_IMPL_MASK) == READ_IDLE)
    ) else $error("unimplemented enable bit reads as one");

    enable_rw_a: assert property ( // [R7]
        BUS_WR_I && BUS_ADDR_I == OFF_ENABLE ##1 BUS_RD_I && BUS_ADDR_I == OFF_ENABLE
        && !BUS_WR_I |=> BUS_RDATA_O == ($past(BUS_WDATA_I, 2) & SRC_IMPL_MASK)
    ) else $error("enable register does not read back");

    enable_reset_a: assert property (@(posedge CLOCK_I) disable iff (1'b0) // [R7]
        SYS_RST_I |=> enable_q == ENABLE_RST && ctrl_q == CTRL_RST
    ) else $error("enables not cleared by reset");

    clk_tune_gate_a: assert property ( // [R8]
        s_en_wr(BIT_CLK_TUNE, 1'b0) |=> !src_req[BIT_CLK_TUNE]
    ) else $error("clock tuning request passed a cleared enable");

    master_gate_a: assert property ( // [R9]
        BUS_WR_I && BUS_ADDR_I == OFF_CTRL && !BUS_WDATA_I[CTRL_PERIPH_BIT]
        |=> !PERIPH_REQ_O && !CORE_IRQ_O
    ) else $error("request left the bank without the master enable");

    flag_sets_a: assert property ( // [R10]
        SRC_EVENT_I[BIT_USB] |=> pending_q[BIT_USB]
    ) else $error("pending flag missed its event");

    group_or_a: assert property ( // [R11]
        $rose(pending_q[BIT_CMP_ONE]) && enable_q[BIT_CMP_ONE] && periph_en
        |-> PERIPH_REQ_O ##1 (stat_q[BIT_CMP_ONE] || !src_req[BIT_CMP_ONE])
    ) else $error("group request or event status missing");

    irq_level_a: assert property (
        BUS_RD_I && BUS_ADDR_I == OFF_IRQ_STAT && src_rise == '0 |=> !IRQ_O
    ) else $error("interrupt stayed high after status read");

    read_idle_a: assert property (
        !BUS_RD_I |=> BUS_RDATA_O == READ_IDLE
    ) else $error("read data not idle outside a read answer");

    stat_read_a: assert property (
        BUS_RD_I && BUS_ADDR_I == OFF_IRQ_STAT |=> BUS_RDATA_O == $past(stat_q)
    ) else $error("status read returned a wrong value");

    unmapped_read_a: assert property (
        BUS_RD_I && BUS_ADDR_I > OFF_IRQ_MASK |=> BUS_RDATA_O == READ_IDLE
    ) else $error("unmapped offset returned data");

    ctrl_write_a: assert property (
        BUS_WR_I && BUS_ADDR_I == OFF_CTRL
        |=> ctrl_q == ($past(BUS_WDATA_I) & CTRL_IMPL_MASK)
    ) else $error("control bits do not follow a write");

    mask_write_a: assert property (
        BUS_WR_I && BUS_ADDR_I == OFF_IRQ_MASK
        |=> mask_q == ($past(BUS_WDATA_I) & SRC_IMPL_MASK)
    ) else $error("mask bits do not follow a write");

    pending_write_a: assert property (
        BUS_WR_I && BUS_ADDR_I == OFF_PENDING && SRC_EVENT_I == '0
        |=> pending_q == ($past(BUS_WDATA_I) & SRC_IMPL_MASK)
    ) else $error("pending flags do not follow a write");

    stat_edge_a: assert property ( // [R11]
        $rose(src_req[BIT_USB]) |=> stat_q[BIT_USB]
    ) else $error("usb request edge not latched in status");

    periph_gate_a: assert property ( // [R9]
        !ctrl_q[CTRL_PERIPH_BIT] |-> !PERIPH_REQ_O && !CORE_IRQ_O
    ) else $error("request left the bank with the master enable clear");

    global_gate_a: assert property (
        !ctrl_q[CTRL_GLOBAL_BIT] |-> !CORE_IRQ_O
    ) else $error("core request raised with the global enable clear");

    stat_clear_a: assert property (
        BUS_RD_I && BUS_ADDR_I == OFF_IRQ_STAT && src_rise == '0 |=> stat_q == '0
    ) else $error("status not cleared by its read");

endmodule
`default_nettype wire

// *** core/pib_pkg.sv ***
`default_nettype none
package pib_pkg;

    // ------------------------------------------------------------
    // bus and register geometry
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;

    localparam logic [ADDR_W-1:0] OFF_ENABLE = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_PENDING = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h4;

    // ------------------------------------------------------------
    // source bit positions, shared by enable, pending, status, mask
    // ------------------------------------------------------------
    localparam int unsigned BIT_OSC_FAIL = 7;
    localparam int unsigned BIT_CMP_TWO = 6;
    localparam int unsigned BIT_CMP_ONE = 5;
    localparam int unsigned BIT_HOLE_HI = 4;
    localparam int unsigned BIT_SER_COLL = 3;
    localparam int unsigned BIT_USB = 2;
    localparam int unsigned BIT_CLK_TUNE = 1;
    localparam int unsigned BIT_HOLE_LO = 0;

    localparam logic [DATA_W-1:0] SRC_IMPL_MASK = 8'hEE;
    localparam logic [DATA_W-1:0] ENABLE_RST = 8'h00;
    localparam logic [DATA_W-1:0] PENDING_RST = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_GLOBAL_BIT = 7;
    localparam int unsigned CTRL_PERIPH_BIT = 6;
    localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 8'hC0;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pib_bus_t;

endpackage
`default_nettype wire

// *** core/pib_rw_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module pib_rw_reg #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] IMPL = '1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_q;

    // holes never store anything, so they cannot read back as one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_q <= RST & IMPL;
        end else if (we_i) begin
            q_q <= wdata_i & IMPL;
        end
    end

    assign q_o = q_q;
endmodule
`default_nettype wire

// *** core/pib_sticky_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module pib_sticky_reg #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] IMPL = '1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic we_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic rd_clr_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_q;
    logic [W-1:0] base_d;
    logic [W-1:0] q_d;

    // a set in the same cycle as a clear is kept: the set is or-ed last
    always_comb begin
        if (we_i) begin
            base_d = wdata_i;
        end else if (rd_clr_i) begin
            base_d = '0;
        end else begin
            base_d = q_q;
        end
        q_d = (base_d | set_i) & IMPL;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_q <= RST & IMPL;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_o = q_q;
endmodule
`default_nettype wire

// *** dv/tb_pib_irq_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_pib_irq_bank;
    import pib_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] ev = '0;
    wire logic [DATA_W-1:0] rdata;
    wire logic preq;
    wire logic creq;
    wire logic irq;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    // xorshift state, starts at 25766
    logic [31:0] seed = 32'h0000_64A6;

    pib_irq_bank i_pib_irq_bank (
        .CLOCK_I(clk),
        .SYS_RST_I(rst),
        .BUS_WR_I(wr),
        .BUS_RD_I(rd),
        .BUS_ADDR_I(addr),
        .BUS_WDATA_I(wdata),
        .BUS_RDATA_O(rdata),
        .SRC_EVENT_I(ev),
        .PERIPH_REQ_O(preq),
        .CORE_IRQ_O(creq),
        .IRQ_O(irq)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // a hung handshake must still end in the closing report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // pending is cleared before each pulse, so it equals the pulse on live bits
    function automatic logic exp_req(input logic [7:0] c, input logic [7:0] e,
                                     input logic [7:0] v);
        return c[6] & (|(e & v & 8'hEE));
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check("rdata", rdata, exp);
    endtask

    // write then read the enable register back to back, an event in the read cycle
    task automatic wr_rd_enable(input logic [7:0] d, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= OFF_ENABLE;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        ev <= v;
        @(posedge clk);
        rd <= 1'b0;
        ev <= 8'h00;
        @(negedge clk);
        check("rdata", rdata, d & SRC_IMPL_MASK);
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 8'h00;
        @(negedge clk);
    endtask

    task automatic trial(input logic [7:0] c, input logic [7:0] e, input logic [7:0] v);
        wr_reg(OFF_PENDING, 8'h00);
        wr_reg(OFF_ENABLE, e);
        wr_reg(OFF_CTRL, c);
        pulse(v);
        check("periph_req", {7'h00, preq}, {7'h00, exp_req(c, e, v)});
        check("core_irq", {7'h00, creq}, {7'h00, exp_req(c, e, v) & c[7]});
        rd_chk(OFF_PENDING, v & 8'hEE);
        rd_chk(OFF_ENABLE, e & 8'hEE);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        int bits[6];
        bits = '{7, 6, 5, 3, 2, 1};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
        // unmapped offsets must not alias onto live registers
        for (int a = 5; a < 8; a++) begin
            wr_reg(a[2:0], 8'hFF);
            rd_chk(a[2:0], 8'h00);
        end
        // dead bits of control and mask drop writes
        wr_reg(OFF_CTRL, 8'hFF);
        rd_chk(OFF_CTRL, CTRL_IMPL_MASK);
        wr_reg(OFF_IRQ_MASK, 8'hFF);
        rd_chk(OFF_IRQ_MASK, SRC_IMPL_MASK);
        rd_chk(OFF_ENABLE, 8'h00);
        // status and mask: only the usb source is masked in
        wr_reg(OFF_IRQ_MASK, 8'h04);
        wr_reg(OFF_ENABLE, 8'hEE);
        wr_reg(OFF_CTRL, 8'hC0);
        pulse(8'h04);
        @(negedge clk);
        check("irq", {7'h00, irq}, 8'h01);
        rd_chk(OFF_IRQ_STAT, 8'h04);
        check("irq", {7'h00, irq}, 8'h00);
        pulse(8'h02);
        @(negedge clk);
        check("irq", {7'h00, irq}, 8'h00);
        rd_chk(OFF_IRQ_STAT, 8'h02);
        // back-to-back strobes, with a collision event in the read cycle
        wr_reg(OFF_PENDING, 8'h40);
        wr_rd_enable(8'h48, 8'h08);
        check("periph_req", {7'h00, preq}, 8'h01);
        @(negedge clk);
        check("rdata", rdata, READ_IDLE);
        rd_chk(OFF_PENDING, 8'h48);
        // each live bit alone: passes, blocked by its own enable, ignores others
        foreach (bits[i]) begin
            trial(8'hC0, 8'h01 << bits[i], 8'h01 << bits[i]);
            trial(8'hC0, ~(8'h01 << bits[i]), 8'h01 << bits[i]);
            trial(8'hC0, 8'h01 << bits[i], ~(8'h01 << bits[i]));
        end
        trial(8'hC0, 8'hFF, 8'h11);
        trial(8'h80, 8'hEE, 8'hEE);
        trial(8'h40, 8'hEE, 8'hEE);
        trial(8'h00, 8'hEE, 8'hEE);
        repeat (16) begin
            r = rnd();
            trial(r[31:24], r[7:0], r[15:8]);
        end
        // reset in mid-run clears the enables again
        wr_reg(OFF_ENABLE, 8'hEE);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFF_ENABLE, 8'h00);
        check("periph_req", {7'h00, preq}, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
